/* File: logic/ecp_host_port.sv */
// extended capabilities parallel host port: registers, shared queue, engines
// assumes a one-cycle register port on I_MCLK and asynchronous link pins
//
// Summary of operation
// RL1 - every port word crosses as eight bits
// RL2 - all queue views share one 16-byte buffer
// RL3 - run-length byte repeats next data, not stored
// RL4 - decompression built, compression left out
// RL5 - forward byte captured on interlocked strobe edge
// RL6 - peripheral busy low means ready for data
// RL7 - peripheral ack marks reverse command or data
// RL8 - peripheral clock low marks valid reverse data
// RL9 - host ack low requests reverse byte, interlocked
// RL10 - host ack marks forward address or data
// RL11 - direction request low reverse, high forward
// RL12 - peripheral grants reverse by pulling grant low
// RL13 - no data drive until grant allows it
// RL14 - peripheral drives only with host ack low
// RL15 - attention line raises error interrupt forward
// RL16 - attention only hints; host owns direction
// RL17 - extended select held deasserted in extended mode
// RL18 - no negotiation; automatic burst both directions with dma
// RL19 - compatibility handshake runs in hardware too
// RL20 - status and control reachable in every mode
// RL21 - config b reports irq and dma selection
// RL22 - mode 011 enables extended queues
// RL23 - address queue bytes tagged, sent forward only
// RL24 - command bit7 clear gives repeat count plus one
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "ecp_params.svh"

module ecp_host_port (
	input  wire logic        I_MCLK,
	input  wire logic        I_SYS_RST,
	input  wire logic [10:0] I_ADDR,
	input  wire logic [7:0]  I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [7:0]  O_RDATA,
	input  wire logic [2:0]  I_CFG_IRQ_SEL,
	input  wire logic [2:0]  I_CFG_DMA_SEL,
	input  wire logic        I_PERIPH_VALID_CLOCK,
	input  wire logic        I_PERIPH_FLOW_ACK,
	input  wire logic        I_REVERSE_GRANT,
	input  wire logic        I_SELECT,
	input  wire logic        I_PERIPH_ATTENTION,
	input  wire logic [7:0]  I_PARALLEL_DATA_LINES,
	output logic      [7:0]  O_PARALLEL_DATA_LINES,
	output logic             O_PARALLEL_DATA_LINES_OE,
	output logic             O_HOST_CLOCK_STROBE,
	output logic             O_HOST_FLOW_ACK,
	output logic             O_DIRECTION_REQUEST,
	output logic             O_SELECT_IN_LINE,
	output logic             O_ERROR_IRQ,
	output logic             O_DMA_REQ
);

	// ==========================================
	// helpers
	function automatic logic is_fifo_mode(input logic [2:0] m);
		is_fifo_mode = (m == `ECP_MODE_COMPAT_OUTPUT_QUEUE) || (m == `ECP_MODE_ECP) ||
			(m == `ECP_MODE_TEST);
	endfunction

	function automatic logic is_ecp_rev(input logic [2:0] m, input logic dir);
		is_ecp_rev = (m == `ECP_MODE_ECP) && dir;
	endfunction

	// ==========================================
	// state
	ecp_pkg::ecp_state_t state_reg;
	ecp_pkg::ecp_state_t state_next;

	logic       clk_s;
	logic       busy_s;
	logic       grant_s;
	logic       sel_s;
	logic       attn_s;
	logic [7:0] pd_s;
	logic       dir;
	logic       rev;
	logic       full;
	logic       fwd_ok;
	logic       push_v;
	logic [8:0] push_d;
	logic       pop_v;

	always_comb begin
		state_next = state_reg;
		push_v = 1'b0;
		push_d = 9'h000;
		pop_v = 1'b0;
		clk_s = state_reg.s2[`ECP_S_PCLK];
		busy_s = state_reg.s2[`ECP_S_BUSY];
		grant_s = state_reg.s2[`ECP_S_GRANT];
		sel_s = state_reg.s2[`ECP_S_SEL];
		attn_s = state_reg.s2[`ECP_S_ATTN];
		pd_s = state_reg.s2[`ECP_S_PD_LO +: 8];
		dir = state_reg.dcr[`ECP_DCR_DIR];
		rev = is_ecp_rev(state_reg.mode, dir);
		full = (state_reg.cnt == 5'(`ECP_DEPTH));
		fwd_ok = (state_reg.mode == `ECP_MODE_COMPAT_OUTPUT_QUEUE) ||
			((state_reg.mode == `ECP_MODE_ECP) && !dir && grant_s);

		// pins pass two flops before use
		state_next.s1 = {I_PARALLEL_DATA_LINES, I_PERIPH_ATTENTION, I_SELECT, I_REVERSE_GRANT,
			I_PERIPH_FLOW_ACK, I_PERIPH_VALID_CLOCK};
		state_next.s2 = state_reg.s1;

		// ==========================================
		// register writes
		if (I_WR) begin
			case (I_ADDR)
				`ECP_OFS_DATA: begin
					if (state_reg.mode == `ECP_MODE_ECP) begin
						if (!dir && !full) begin
							push_v = 1'b1; // RL23
							push_d = {1'b1, I_WDATA};
						end
					end else if (!is_fifo_mode(state_reg.mode)) begin
						state_next.data_latch = I_WDATA;
					end
				end
				`ECP_OFS_DCR: state_next.dcr = I_WDATA[5:0]; // RL20
				`ECP_OFS_FIFO: begin
					if (is_fifo_mode(state_reg.mode) && !rev && !full) begin
						push_v = 1'b1; // RL2
						push_d = {1'b0, I_WDATA};
					end
				end
				`ECP_OFS_ECR: begin
					state_next.mode = I_WDATA[7:5]; // RL22
					state_next.err_en_n = I_WDATA[`ECP_ECR_ERRN];
					state_next.dma_en = I_WDATA[`ECP_ECR_DMA];
					state_next.svc = I_WDATA[`ECP_ECR_SVC];
				end
				default: begin
				end
			endcase
		end

		// ==========================================
		// register reads, data one cycle later
		state_next.o_rdata = 8'h00;
		if (I_RD) begin
			case (I_ADDR)
				`ECP_OFS_DATA:
					if (!is_fifo_mode(state_reg.mode))
						state_next.o_rdata = pd_s;
				`ECP_OFS_DSR: // RL20
					state_next.o_rdata = {~busy_s, clk_s, grant_s, sel_s, attn_s, 3'h0};
				`ECP_OFS_DCR: state_next.o_rdata = {2'h0, state_reg.dcr};
				`ECP_OFS_FIFO: begin
					if (state_reg.mode == `ECP_MODE_CFG) begin
						state_next.o_rdata = `ECP_FIXED_CAPABILITY_A_VAL;
					end else if (rev || (state_reg.mode == `ECP_MODE_TEST)) begin
						if (state_reg.cnt != 5'h00) begin
							pop_v = 1'b1;
							state_next.o_rdata = state_reg.mem[state_reg.rp][7:0];
							state_next.last = state_reg.mem[state_reg.rp][7:0];
						end else begin
							state_next.o_rdata = state_reg.last;
						end
					end
				end
				`ECP_OFS_CHANNEL_RESOURCE_B:
					if (state_reg.mode == `ECP_MODE_CFG) // RL21 RL4
						state_next.o_rdata = {1'b0, state_reg.o_err, I_CFG_IRQ_SEL,
							I_CFG_DMA_SEL};
				`ECP_OFS_ECR:
					state_next.o_rdata = {state_reg.mode, state_reg.err_en_n,
						state_reg.dma_en, state_reg.svc, full, state_reg.cnt == 5'h00};
				default: state_next.o_rdata = 8'h00;
			endcase
		end

		// ==========================================
		// forward engine, extended and compatibility
		case (state_reg.fw)
			ecp_pkg::FW_IDLE: begin
				state_next.strobe_n = 1'b1;
				if (fwd_ok && state_reg.cnt != 5'h00 && !pop_v) begin
					pop_v = 1'b1;
					state_next.cur = state_reg.mem[state_reg.rp];
					if (state_reg.mode == `ECP_MODE_ECP)
						state_next.host_flow_ack = ~state_reg.mem[state_reg.rp][`ECP_TAG_BIT]; // RL10
					state_next.fw = ecp_pkg::FW_DRIVE;
				end
			end
			ecp_pkg::FW_DRIVE: begin
				if (!busy_s) begin
					state_next.strobe_n = 1'b0; // RL5 RL6 RL19
					state_next.fw = ecp_pkg::FW_STROBE;
				end
			end
			ecp_pkg::FW_STROBE: begin
				if (busy_s) begin
					state_next.strobe_n = 1'b1; // RL5
					state_next.fw = ecp_pkg::FW_IDLE;
				end
			end
			default: state_next.fw = ecp_pkg::FW_IDLE;
		endcase

		// ==========================================
		// reverse engine with run-length expansion
		case (state_reg.rv)
			ecp_pkg::RV_IDLE: begin
				if (rev && !grant_s && !full) begin
					state_next.host_flow_ack = 1'b0; // RL9
					state_next.rv = ecp_pkg::RV_WAIT;
				end
			end
			ecp_pkg::RV_WAIT: begin
				// turned back before the byte came: withdraw the request
				if (!rev) begin
					state_next.host_flow_ack = 1'b1;
					state_next.rv = ecp_pkg::RV_IDLE;
				end else if (!clk_s) begin // RL8
					if (busy_s) begin // RL7
						state_next.cap = pd_s;
						state_next.rep = state_reg.repeat_count_code;
						state_next.repeat_count_code = `ECP_RLE_RST;
					end else if (!pd_s[`ECP_RLE_FLAG]) begin
						state_next.repeat_count_code = 8'({1'b0, pd_s[6:0]} + 8'h01); // RL3 RL24
					end
					state_next.host_flow_ack = 1'b1; // RL9
					state_next.rv = ecp_pkg::RV_ACK;
				end
			end
			ecp_pkg::RV_ACK: begin
				if (clk_s)
					state_next.rv = ecp_pkg::RV_REPEAT;
			end
			ecp_pkg::RV_REPEAT: begin
				if (state_reg.rep == 8'h00) begin
					state_next.rv = ecp_pkg::RV_IDLE;
				end else if (!full && !push_v) begin
					push_v = 1'b1; // RL3
					push_d = {1'b0, state_reg.cap};
					state_next.rep = state_reg.rep - 8'h01;
				end
			end
			default: state_next.rv = ecp_pkg::RV_IDLE;
		endcase

		// ==========================================
		// shared queue
		if (push_v) begin
			state_next.mem[state_reg.wp] = push_d; // RL1 RL2
			state_next.wp = state_reg.wp + 4'h1;
		end
		if (pop_v)
			state_next.rp = state_reg.rp + 4'h1;
		state_next.cnt = 5'(state_reg.cnt + {4'h0, push_v} - {4'h0, pop_v});

		// leaving the queue modes empties it and stops the engines
		if (!is_fifo_mode(state_next.mode)) begin
			state_next.wp = 4'h0;
			state_next.rp = 4'h0;
			state_next.cnt = 5'h00;
			state_next.fw = ecp_pkg::FW_IDLE;
			state_next.rv = ecp_pkg::RV_IDLE;
			state_next.strobe_n = 1'b1;
			state_next.host_flow_ack = 1'b1;
			state_next.rep = 8'h00;
			state_next.repeat_count_code = `ECP_RLE_RST;
		end

		// service flag: hardware set wins over software clear
		if (is_fifo_mode(state_reg.mode) && !state_reg.dma_en &&
			(rev ? state_reg.cnt >= `ECP_SVC_LEVEL : state_reg.cnt < `ECP_SVC_LEVEL))
			state_next.svc = 1'b1;

		// ==========================================
		// pin outputs
		case (state_next.mode)
			`ECP_MODE_ECP: begin
				state_next.o_strobe = state_next.strobe_n;
				state_next.o_afd = state_next.host_flow_ack;
				state_next.o_init = ~state_next.dcr[`ECP_DCR_DIR]; // RL11 RL16
				state_next.o_selin = 1'b1; // RL17
				state_next.o_pd = state_next.cur[7:0];
				state_next.o_pd_oe = ~state_next.dcr[`ECP_DCR_DIR] && grant_s; // RL13
			end
			`ECP_MODE_COMPAT_OUTPUT_QUEUE: begin
				state_next.o_strobe = state_next.strobe_n; // RL19
				state_next.o_afd = ~state_next.dcr[`ECP_DCR_AFD];
				state_next.o_init = state_next.dcr[`ECP_DCR_INIT];
				state_next.o_selin = ~state_next.dcr[`ECP_DCR_SELIN];
				state_next.o_pd = state_next.cur[7:0];
				state_next.o_pd_oe = 1'b1;
			end
			default: begin
				state_next.o_strobe = ~state_next.dcr[`ECP_DCR_STB];
				state_next.o_afd = ~state_next.dcr[`ECP_DCR_AFD];
				state_next.o_init = state_next.dcr[`ECP_DCR_INIT];
				state_next.o_selin = ~state_next.dcr[`ECP_DCR_SELIN];
				state_next.o_pd = state_next.data_latch;
				state_next.o_pd_oe = (state_next.mode == `ECP_MODE_SPP) ||
					~state_next.dcr[`ECP_DCR_DIR];
			end
		endcase
		state_next.o_err = (state_reg.mode == `ECP_MODE_ECP) && !dir && !attn_s &&
			!state_reg.err_en_n; // RL15 RL16
		state_next.o_dma = state_reg.dma_en && is_fifo_mode(state_reg.mode) &&
			(rev ? state_reg.cnt != 5'h00 : !full); // RL18

		if (I_SYS_RST) begin
			state_next = '0;
			state_next.dcr = `ECP_DCR_RST;
			state_next.data_latch = `ECP_DATA_RST;
			state_next.mode = `ECP_MODE_SPP;
			state_next.err_en_n = 1'b1;
			state_next.repeat_count_code = `ECP_RLE_RST;
			state_next.fw = ecp_pkg::FW_IDLE;
			state_next.rv = ecp_pkg::RV_IDLE;
			state_next.strobe_n = 1'b1;
			state_next.host_flow_ack = 1'b1;
			state_next.o_strobe = 1'b1;
			state_next.o_afd = 1'b1;
			state_next.o_selin = 1'b1;
			state_next.o_pd_oe = 1'b1;
		end
	end

	always_ff @(posedge I_MCLK) begin
		state_reg <= state_next;
	end

	assign O_RDATA = state_reg.o_rdata;
	assign O_PARALLEL_DATA_LINES = state_reg.o_pd;
	assign O_PARALLEL_DATA_LINES_OE = state_reg.o_pd_oe;
	assign O_HOST_CLOCK_STROBE = state_reg.o_strobe;
	assign O_HOST_FLOW_ACK = state_reg.o_afd;
	assign O_DIRECTION_REQUEST = state_reg.o_init;
	assign O_SELECT_IN_LINE = state_reg.o_selin;
	assign O_ERROR_IRQ = state_reg.o_err;
	assign O_DMA_REQ = state_reg.o_dma;

	// ==========================================
	// checks
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);

	a_selin_ecp_high: assert property ( // RL17
		state_reg.mode == `ECP_MODE_ECP |-> O_SELECT_IN_LINE == 1'b1)
		else $error("select in driven low in extended mode");
	a_dir_request: assert property ( // RL11
		state_reg.mode == `ECP_MODE_ECP && $stable(state_reg.mode) |->
		O_DIRECTION_REQUEST == !state_reg.dcr[`ECP_DCR_DIR])
		else $error("direction request does not follow direction");
	a_no_rev_drive: assert property ( // RL13
		state_reg.mode == `ECP_MODE_ECP && !grant_s
		##1 $stable(grant_s) && $stable(state_reg.mode) |-> !O_PARALLEL_DATA_LINES_OE)
		else $error("data driven without forward grant");
	a_strobe_data: assert property ( // RL5
		$fell(O_HOST_CLOCK_STROBE) && state_reg.mode == `ECP_MODE_ECP |->
		O_PARALLEL_DATA_LINES_OE && $stable(O_PARALLEL_DATA_LINES))
		else $error("strobe asserted without stable data");
	a_rev_request: assert property ( // RL9
		$fell(O_HOST_FLOW_ACK) && state_reg.rv == ecp_pkg::RV_WAIT |->
		$past(!grant_s) && $past(state_reg.cnt) < 5'(`ECP_DEPTH))
		else $error("reverse request without grant or room");
	a_rle_count: assert property ( // RL24
		state_reg.rv == ecp_pkg::RV_WAIT && rev && !clk_s && !busy_s && !pd_s[7] |=>
		state_reg.repeat_count_code == 8'({1'b0, $past(pd_s[6:0])} + 8'h01))
		else $error("repeat count not count plus one");
	a_queue_depth: assert property ( // RL2
		state_reg.cnt <= 5'(`ECP_DEPTH))
		else $error("queue count beyond depth");
	a_err_irq: assert property ( // RL15
		state_reg.mode == `ECP_MODE_ECP && !dir && !attn_s && !state_reg.err_en_n
		|=> O_ERROR_IRQ)
		else $error("attention did not raise error interrupt");
	a_fwd_tag: assert property ( // RL10
		state_reg.fw == ecp_pkg::FW_STROBE && state_reg.mode == `ECP_MODE_ECP |->
		O_HOST_FLOW_ACK == !state_reg.cur[`ECP_TAG_BIT])
		else $error("host ack does not mark address or data");
	a_repeat_push: assert property ( // RL3
		state_reg.rv == ecp_pkg::RV_REPEAT && state_reg.rep != 8'h00 && !full |=>
		state_reg.rep == $past(state_reg.rep) - 8'h01)
		else $error("repeat run did not advance");

	c_fwd_byte: cover property (state_reg.fw == ecp_pkg::FW_STROBE ##1
		state_reg.fw == ecp_pkg::FW_IDLE);
	c_rev_byte: cover property (state_reg.rv == ecp_pkg::RV_ACK ##1
		state_reg.rv == ecp_pkg::RV_REPEAT);
	c_rle_run: cover property (state_reg.rv == ecp_pkg::RV_REPEAT &&
		state_reg.rep > 8'h02);

endmodule

/* File: logic/ecp_params.svh */
// constants of the extended capabilities host port: offsets, fields, resets
// assumes inclusion by the package and by the port module only
`ifndef ECP_PARAMS_SVH
`define ECP_PARAMS_SVH

// ==========================================
// register offsets from the port base
`define ECP_OFS_DATA   11'h000
`define ECP_OFS_DSR    11'h001
`define ECP_OFS_DCR    11'h002
`define ECP_OFS_FIFO   11'h400
`define ECP_OFS_CHANNEL_RESOURCE_B  11'h401
`define ECP_OFS_ECR    11'h402

// ==========================================
// mode field codes
`define ECP_MODE_SPP   3'h0
`define ECP_MODE_PS2   3'h1
`define ECP_MODE_COMPAT_OUTPUT_QUEUE 3'h2
`define ECP_MODE_ECP   3'h3
`define ECP_MODE_TEST  3'h6
`define ECP_MODE_CFG   3'h7

// ==========================================
// field positions
`define ECP_DCR_STB    0
`define ECP_DCR_AFD    1
`define ECP_DCR_INIT   2
`define ECP_DCR_SELIN  3
`define ECP_DCR_DIR    5
`define ECP_ECR_ERRN   4
`define ECP_ECR_DMA    3
`define ECP_ECR_SVC    2
`define ECP_TAG_BIT    8
`define ECP_RLE_FLAG   7
// synchroniser lanes
`define ECP_S_PCLK     0
`define ECP_S_BUSY     1
`define ECP_S_GRANT    2
`define ECP_S_SEL      3
`define ECP_S_ATTN     4
`define ECP_S_PD_LO    5

// ==========================================
// sizes and reset values
`define ECP_WORD       8
`define ECP_DEPTH      16
`define ECP_SVC_LEVEL  5'h08
`define ECP_DCR_RST    6'h00
`define ECP_DATA_RST   8'h00
`define ECP_RLE_RST    8'h01
`define ECP_FIXED_CAPABILITY_A_VAL  8'h10

`endif

/* File: logic/ecp_pkg.sv */
// types of the extended capabilities host port
// assumes ecp_params.svh is on the include path
`include "ecp_params.svh"

package ecp_pkg;

	// ==========================================
	// engine states
	typedef enum logic [1:0] {FW_IDLE, FW_DRIVE, FW_STROBE} ecp_fwd_t;
	typedef enum logic [1:0] {RV_IDLE, RV_WAIT, RV_ACK, RV_REPEAT} ecp_rev_t;

	// ==========================================
	// whole state of the port
	typedef struct packed {
		logic [`ECP_DEPTH-1:0][`ECP_WORD:0] mem;
		logic [3:0]                         wp;
		logic [3:0]                         rp;
		logic [4:0]                         cnt;
		logic [12:0]                        s1;
		logic [12:0]                        s2;
		logic [7:0]                         data_latch;
		logic [5:0]                         dcr;
		logic [2:0]                         mode;
		logic                               err_en_n;
		logic                               dma_en;
		logic                               svc;
		logic [7:0]                         last;
		logic [8:0]                         cur;
		logic [7:0]                         cap;
		logic [7:0]                         rep;
		logic [7:0]                         repeat_count_code;
		ecp_fwd_t                           fw;
		ecp_rev_t                           rv;
		logic                               strobe_n;
		logic                               host_flow_ack;
		logic                               o_strobe;
		logic                               o_afd;
		logic                               o_init;
		logic                               o_selin;
		logic [7:0]                         o_pd;
		logic                               o_pd_oe;
		logic                               o_err;
		logic                               o_dma;
		logic [7:0]                         o_rdata;
	} ecp_state_t;

endpackage

/* File: test/ecp_periph_model.sv */
// peripheral model facing the extended capabilities host port
// assumes a free-running model clock from the bench, unrelated to I_MCLK
`timescale 1ns/10ps

module ecp_periph_model (
	input  wire logic       i_clk,
	input  wire logic       i_strobe_n,
	input  wire logic       i_host_ack,
	input  wire logic       i_dir_req,
	input  wire logic [7:0] i_pd,
	output logic            o_valid_clk,
	output logic            o_busy,
	output logic            o_grant,
	output logic [7:0]      o_pd,
	output logic            o_pd_oe
);
	logic [8:0] rx_q [$];
	logic [8:0] tx_q [$];
	logic [8:0] tx_word;

	initial begin
		o_valid_clk = 1'b1;
		o_busy      = 1'b0;
		o_grant     = 1'b1;
		o_pd        = 8'hFF;
		o_pd_oe     = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_dir_req !== o_grant) begin
				o_grant <= i_dir_req;
				o_busy  <= 1'b0;
			end else if (o_grant && !i_strobe_n) begin
				rx_q.push_back({i_host_ack, i_pd});
				o_busy <= 1'b1;
				wait (i_strobe_n);
				@(posedge i_clk);
				o_busy <= 1'b0;
			end else if (!o_grant && !i_host_ack && tx_q.size() > 0) begin
				tx_word = tx_q.pop_front();
				o_pd_oe <= 1'b1;
				o_pd    <= tx_word[7:0];
				o_busy  <= tx_word[8];
				@(posedge i_clk);
				o_valid_clk <= 1'b0;
				wait (i_host_ack);
				@(posedge i_clk);
				o_valid_clk <= 1'b1;
				o_pd_oe     <= 1'b0;
				// released lines show the inverse, not a held value
				o_pd        <= ~tx_word[7:0];
			end
		end
	end
endmodule

/* File: test/tb_ecp_host_port.sv */
// self-checking bench of the extended capabilities host port
// assumes the peripheral model and the design files compiled before it
`timescale 1ns/10ps

module tb_ecp_host_port;
	typedef struct packed {
		logic        wr;
		logic [10:0] a;
		logic [7:0]  d;
	} ecp_row_t;

	logic        mclk    = 1'b0;
	logic        pclk    = 1'b0;
	logic        sys_rst = 1'b1;
	logic [10:0] addr    = 11'h000;
	logic [7:0]  wdata   = 8'h00;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        attn_n  = 1'b1;
	logic [7:0]  rdata;
	logic [7:0]  dut_pd;
	logic [7:0]  pm_pd;
	logic [7:0]  pd_bus;
	logic        dut_oe;
	logic        pm_oe;
	logic        strobe_n;
	logic        host_ack;
	logic        dir_req;
	logic        sel_in;
	logic        err_irq;
	logic        dma_req;
	logic        valid_clk;
	logic        busy;
	logic        grant;
	logic [7:0]  d;
	int          n_mismatch = 0;
	int          num_checks = 0;
	ecp_row_t    rows [9];

	always #2 mclk = ~mclk;
	initial begin
		#1.3;
		forever #80 pclk = ~pclk;
	end

	assign pd_bus = pm_oe ? pm_pd : (dut_oe ? dut_pd : pm_pd);

	ecp_host_port ecp_host_port_inst (
		.I_MCLK               (mclk),
		.I_SYS_RST            (sys_rst),
		.I_ADDR               (addr),
		.I_WDATA              (wdata),
		.I_WR                 (wr),
		.I_RD                 (rd),
		.O_RDATA              (rdata),
		.I_CFG_IRQ_SEL        (3'h5),
		.I_CFG_DMA_SEL        (3'h3),
		.I_PERIPH_VALID_CLOCK (valid_clk),
		.I_PERIPH_FLOW_ACK    (busy),
		.I_REVERSE_GRANT      (grant),
		.I_SELECT             (1'b1),
		.I_PERIPH_ATTENTION   (attn_n),
		.I_PARALLEL_DATA_LINES              (pd_bus),
		.O_PARALLEL_DATA_LINES              (dut_pd),
		.O_PARALLEL_DATA_LINES_OE           (dut_oe),
		.O_HOST_CLOCK_STROBE  (strobe_n),
		.O_HOST_FLOW_ACK      (host_ack),
		.O_DIRECTION_REQUEST  (dir_req),
		.O_SELECT_IN_LINE     (sel_in),
		.O_ERROR_IRQ          (err_irq),
		.O_DMA_REQ            (dma_req)
	);

	ecp_periph_model ecp_periph_model_inst (
		.i_clk       (pclk),
		.i_strobe_n  (strobe_n),
		.i_host_ack  (host_ack),
		.i_dir_req   (dir_req),
		.i_pd        (pd_bus),
		.o_valid_clk (valid_clk),
		.o_busy      (busy),
		.o_grant     (grant),
		.o_pd        (pm_pd),
		.o_pd_oe     (pm_oe)
	);

	// ==========================================
	// shared tasks
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus_wr(input logic [10:0] a, input logic [7:0] v);
		@(posedge mclk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [10:0] a, output logic [7:0] v);
		@(posedge mclk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wait_rx(input int n);
		for (int i = 0; i < 4000 && ecp_periph_model_inst.rx_q.size() < n; i++)
			@(posedge mclk);
	endtask

	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		rows = '{'{1'b1, 11'h402, 8'hF0}, '{1'b0, 11'h400, 8'h10},
			'{1'b0, 11'h401, 8'h2B}, '{1'b1, 11'h002, 8'hFF},
			'{1'b0, 11'h002, 8'h3F}, '{1'b0, 11'h003, 8'h00},
			'{1'b1, 11'h002, 8'h00}, '{1'b1, 11'h402, 8'h70},
			'{1'b0, 11'h402, 8'h75}};
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				bus_wr(rows[i].a, rows[i].d);
			end else begin
				bus_rd(rows[i].a, d);
				chk({1'b0, d}, {1'b0, rows[i].d});
			end
		end
		// forward: command then data, tag on host ack
		bus_wr(11'h000, 8'h85);
		bus_wr(11'h400, 8'h3C);
		bus_wr(11'h400, 8'hA5);
		wait_rx(3);
		chk(ecp_periph_model_inst.rx_q[0], 9'h085);
		chk(ecp_periph_model_inst.rx_q[1], 9'h13C);
		chk(ecp_periph_model_inst.rx_q[2], 9'h1A5);
		chk({8'h00, dir_req}, 9'h001);
		chk({8'h00, sel_in}, 9'h001);
		// let the peripheral drop busy after the last byte
		cyc(100);
		bus_rd(11'h001, d);
		chk({1'b0, d}, 9'h0F8);
		// compatibility queue
		bus_wr(11'h002, 8'h04);
		bus_wr(11'h402, 8'h50);
		bus_wr(11'h400, 8'h99);
		wait_rx(4);
		chk({1'b0, ecp_periph_model_inst.rx_q[3][7:0]}, 9'h099);
		// attention line
		bus_wr(11'h402, 8'h70);
		attn_n <= 1'b0;
		cyc(10);
		chk({8'h00, err_irq}, 9'h000);
		bus_wr(11'h402, 8'h68);
		cyc(10);
		chk({8'h00, err_irq}, 9'h001);
		chk({8'h00, dir_req}, 9'h001);
		@(posedge mclk);
		attn_n <= 1'b1;
		cyc(10);
		chk({8'h00, err_irq}, 9'h000);
		// reverse with a repeat count
		bus_wr(11'h402, 8'h78);
		cyc(4);
		chk({8'h00, dma_req}, 9'h001);
		ecp_periph_model_inst.tx_q = '{9'h002, 9'h15A, 9'h177};
		bus_wr(11'h002, 8'h20);
		for (int i = 0; i < 5000 && ecp_periph_model_inst.tx_q.size() > 0; i++)
			@(posedge mclk);
		cyc(300);
		chk({8'h00, dir_req}, 9'h000);
		chk({8'h00, dut_oe}, 9'h000);
		chk({8'h00, dma_req}, 9'h001);
		for (int i = 0; i < 5; i++) begin
			bus_rd(11'h400, d);
			chk({1'b0, d}, (i > 2) ? 9'h077 : 9'h05A);
		end
		bus_rd(11'h402, d);
		chk({8'h00, d[0]}, 9'h001);
		cyc(4);
		chk({8'h00, dma_req}, 9'h000);
		bus_wr(11'h002, 8'h00);
		cyc(300);
		// test queue: sixteen bytes fill it, the seventeenth is dropped
		bus_wr(11'h402, 8'hD0);
		for (int i = 0; i < 17; i++)
			bus_wr(11'h400, 8'h40 + 8'(i));
		bus_rd(11'h402, d);
		chk({8'h00, d[1]}, 9'h001);
		for (int i = 0; i < 17; i++) begin
			bus_rd(11'h400, d);
			chk({1'b0, d}, {1'b0, 8'h40 + 8'((i > 15) ? 15 : i)});
		end
		// reset in mid-run
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		cyc(2);
		chk({8'h00, strobe_n}, 9'h001);
		chk({8'h00, sel_in}, 9'h001);
		chk({8'h00, err_irq}, 9'h000);
		bus_rd(11'h402, d);
		chk({1'b0, d}, 9'h011);
		stop_test();
	end

	// ==========================================
	// watchdog
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
endmodule
